// [rtl/cmd_sel_pkg.sv]
// constants for the command source selector: register map, reset values,
// input function codes, source and mode-origin codes, output bit layout
package cmd_sel_pkg;
  localparam int NUM_DI = 6;
  localparam int NUM_SRC = 6;
  localparam int FN_W = 4;
  localparam int SRC_W = 3;
  localparam int ORG_W = 4;
  localparam int WORD_W = 4;
  localparam int NUM_OUT = 13;
  // register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_SRC = 8'h04;
  localparam logic [7:0] ADR_DIFN = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  // field positions
  localparam int SRC_LOC_LSB = 0;
  localparam int SRC_REM_LSB = 4;
  localparam int SRC_COPY_BIT = 8;
  localparam int STAT_REM_BIT = 13;
  localparam int STAT_DI_LSB = 16;
  // reset values
  localparam logic [ORG_W-1:0] ORG_RST = 4'h2;
  localparam logic [SRC_W-1:0] LOC_RST = 3'h0;
  localparam logic [SRC_W-1:0] REM_RST = 3'h1;
  localparam logic COPY_RST = 1'b0;
  localparam logic [NUM_DI*FN_W-1:0] DIFN_RST = 24'h000032;
  // input function codes
  localparam logic [FN_W-1:0] FN_RUN = 4'h1;
  localparam logic [FN_W-1:0] FN_3W_START = 4'h2;
  localparam logic [FN_W-1:0] FN_3W_STOP = 4'h3;
  localparam logic [FN_W-1:0] FN_GEN_EN = 4'h4;
  localparam logic [FN_W-1:0] FN_LOCREM = 4'h5;
  localparam logic [FN_W-1:0] FN_JOG = 4'h6;
  localparam logic [FN_W-1:0] FN_DIR = 4'h7;
  localparam logic [FN_W-1:0] FN_NO_FAULT = 4'h8;
  localparam logic [FN_W-1:0] FN_NO_ALARM = 4'h9;
  localparam logic [FN_W-1:0] FN_BRAKE = 4'ha;
  localparam logic [FN_W-1:0] FN_RESET = 4'hb;
  localparam logic [FN_W-1:0] FN_LOAD_USER = 4'hc;
  localparam logic [FN_W-1:0] FN_EMERG = 4'he;
  // command source codes
  localparam logic [SRC_W-1:0] SRC_KEYPAD = 3'h0;
  localparam logic [SRC_W-1:0] SRC_DIG = 3'h1;
  localparam logic [SRC_W-1:0] SRC_USB = 3'h2;
  localparam logic [SRC_W-1:0] SRC_MAX = 3'h5;
  // mode origin codes
  localparam logic [ORG_W-1:0] ORG_LOCAL = 4'h0;
  localparam logic [ORG_W-1:0] ORG_REMOTE = 4'h1;
  localparam logic [ORG_W-1:0] ORG_KEY_LOC = 4'h2;
  localparam logic [ORG_W-1:0] ORG_KEY_REM = 4'h3;
  localparam logic [ORG_W-1:0] ORG_DIG = 4'h4;
  localparam logic [ORG_W-1:0] ORG_COMM_FIRST = 4'h5;
  localparam logic [ORG_W-1:0] ORG_MAX = 4'hc;
  // command word bits
  localparam int W_RUN = 0;
  localparam int W_ENA = 1;
  localparam int W_REV = 2;
  localparam int W_REM = 3;
  // output and status bits
  localparam int O_RUN = 0;
  localparam int O_FWD = 1;
  localparam int O_REV = 2;
  localparam int O_JOG = 3;
  localparam int O_FAULT = 4;
  localparam int O_ALARM = 5;
  localparam int O_BRAKE = 6;
  localparam int O_QSTOP = 7;
  localparam int O_EMERG = 8;
  localparam int O_FRST = 9;
  localparam int O_LOAD1 = 10;
  localparam int O_LOAD2 = 11;
  localparam int O_LREF = 12;
endpackage

// [rtl/di_sync.sv]
// two-flop synchroniser with edge pulses, one per digital input
// inputs are asynchronous pins; outputs are on the core clock
`timescale 1ns/1ps
module di_sync
  import cmd_sel_pkg::*;
#(
  parameter int W = NUM_DI
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      logic prev_ff;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= pin[i];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      // clean edges from the settled level
      assign lvl[i] = sync_ff;
      assign rise[i] = sync_ff & ~prev_ff;
      assign fall[i] = ~sync_ff & prev_ff;
    end
  endgenerate
endmodule

// [rtl/cmd_word_mux.sv]
// picks one source command word out of the packed words
// sel codes above the last source give an all-zero word
`timescale 1ns/1ps
module cmd_word_mux
  import cmd_sel_pkg::*;
(
  input wire logic [NUM_SRC*WORD_W-1:0] words,
  input wire logic [SRC_W-1:0] sel,
  output logic [WORD_W-1:0] word
);
  always_comb
  begin
    word = '0;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      if (sel == SRC_W'(s))
      begin
        word = words[s*WORD_W +: WORD_W];
      end
    end
  end
endmodule

// [rtl/cmd_source_selector.sv]
// local/remote mode and start/stop command source selection, with decode
// of the programmable digital input functions; wishbone classic slave.
// assumes comm sources and keypad are on CORE_CLK; digital inputs are pins.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module cmd_source_selector
  import cmd_sel_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [NUM_DI-1:0] DIG_INPUT,
  input wire logic KEY_LR_TOGGLE,
  input wire logic [NUM_SRC-1:0] SRC_WE,
  input wire logic [NUM_SRC*WORD_W-1:0] SRC_WORD,
  input wire logic MOTOR_ENABLED,
  input wire logic USER1_SAVED,
  input wire logic USER2_SAVED,
  output logic REMOTE_MODE,
  output logic RUN_CMD,
  output logic FWD_CONTACTOR,
  output logic REV_CONTACTOR,
  output logic JOG_REQ,
  output logic EXT_FAULT,
  output logic EXT_ALARM,
  output logic BRAKE_ALLOW,
  output logic QUICK_STOP,
  output logic EMERGENCY_RUN,
  output logic FAULT_RESET,
  output logic LOAD_USER1,
  output logic LOAD_USER2,
  output logic LOAD_REFUSED
);
  logic [NUM_DI-1:0] di_lvl;
  logic [NUM_DI-1:0] di_rise;
  logic [NUM_DI-1:0] di_fall;
  logic [ORG_W-1:0] origin_ff, nxt_origin;
  logic [SRC_W-1:0] loc_src_ff, nxt_loc_src;
  logic [SRC_W-1:0] rem_src_ff, nxt_rem_src;
  logic copy_ff, nxt_copy;
  logic [NUM_DI*FN_W-1:0] difn_ff, nxt_difn;
  logic remote_ff, nxt_remote;
  logic [NUM_SRC*WORD_W-1:0] word_ff, nxt_word;
  logic tw_run_ff, nxt_tw_run;
  logic [NUM_OUT-1:0] out_ff, nxt_out;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [NUM_DI-1:0] m_run, m_3ws, m_3wp, m_ge, m_lr, m_jog, m_dir;
  logic [NUM_DI-1:0] m_flt, m_alm, m_brk, m_rst, m_load, m_emg;
  logic [NUM_SRC*WORD_W-1:0] mux_words;
  logic [WORD_W-1:0] act_word;
  logic [WORD_W-1:0] di_word;
  logic [SRC_W-1:0] act_src;
  logic [SRC_W-1:0] new_src;
  logic [SRC_W-1:0] comm_src;
  logic [ORG_W-1:0] org_off;
  logic lr_lvl, ge_ok, emg_asg, load_rise, load_fall;
  logic wr_req;
  logic [31:0] wmask;
  logic [31:0] wr_mode, wr_src, wr_difn;

  di_sync #(
    .W(NUM_DI)
  ) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .pin(DIG_INPUT),
    .lvl(di_lvl),
    .rise(di_rise),
    .fall(di_fall)
  );

  // per-input function decode
  always_comb
  begin
    logic [FN_W-1:0] fn;
    fn = '0;
    m_run = '0;
    m_3ws = '0;
    m_3wp = '0;
    m_ge = '0;
    m_lr = '0;
    m_jog = '0;
    m_dir = '0;
    m_flt = '0;
    m_alm = '0;
    m_brk = '0;
    m_rst = '0;
    m_load = '0;
    m_emg = '0;
    for (int i = 0; i < NUM_DI; i++)
    begin
      fn = difn_ff[i*FN_W +: FN_W];
      m_run[i] = (fn == FN_RUN);
      m_3ws[i] = (fn == FN_3W_START);
      m_3wp[i] = (fn == FN_3W_STOP);
      m_ge[i] = (fn == FN_GEN_EN);
      m_lr[i] = (fn == FN_LOCREM);
      m_jog[i] = (fn == FN_JOG);
      m_dir[i] = (fn == FN_DIR);
      m_flt[i] = (fn == FN_NO_FAULT);
      m_alm[i] = (fn == FN_NO_ALARM);
      m_brk[i] = (fn == FN_BRAKE);
      m_rst[i] = (fn == FN_RESET);
      m_load[i] = (fn == FN_LOAD_USER);
      m_emg[i] = (fn == FN_EMERG);
    end
  end

  // open is local, closed is remote
  assign lr_lvl = |(m_lr & di_lvl);
  // every enable input must be closed; none assigned never blocks
  assign ge_ok = &(~m_ge | di_lvl);
  assign emg_asg = |m_emg;
  assign load_rise = |(m_load & di_rise);
  assign load_fall = |(m_load & di_fall);

  // digital source word: run/stop level or three-wire latch
  always_comb
  begin
    di_word = '0;
    di_word[W_RUN] = (|m_run) ? |(m_run & di_lvl) : tw_run_ff;
    di_word[W_ENA] = 1'b1;
    di_word[W_REV] = |(m_dir & di_lvl);
  end

  // three-wire start sets, any open stop button clears
  always_comb
  begin
    nxt_tw_run = tw_run_ff;
    if (|(m_3ws & di_rise))
    begin
      nxt_tw_run = 1'b1;
    end
    if (|(m_3wp & ~di_lvl))
    begin
      nxt_tw_run = 1'b0;
    end
  end

  assign act_src = remote_ff ? rem_src_ff : loc_src_ff;
  assign new_src = nxt_remote ? rem_src_ff : loc_src_ff;
  always_comb
  begin
    mux_words = word_ff;
    mux_words[SRC_DIG*WORD_W +: WORD_W] = di_word;
  end

  cmd_word_mux u_mux (
    .words(mux_words),
    .sel(act_src),
    .word(act_word)
  );

  // comm source of origin codes 5 to 12
  assign org_off = origin_ff - ORG_COMM_FIRST;
  assign comm_src = SRC_USB + SRC_W'(org_off[3:1]);

  // wishbone write decode with byte lanes
  assign wr_req = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_ff;
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{WB_SEL_I[b]}};
    end
  end
  assign wr_mode = (32'(origin_ff) & ~wmask) | (WB_DAT_I & wmask);
  assign wr_src = ({23'h0, copy_ff, 1'b0, rem_src_ff, 1'b0, loc_src_ff} & ~wmask)
    | (WB_DAT_I & wmask);
  assign wr_difn = ({8'h00, difn_ff} & ~wmask) | (WB_DAT_I & wmask);

  // configuration registers
  always_comb
  begin
    nxt_origin = origin_ff;
    nxt_loc_src = loc_src_ff;
    nxt_rem_src = rem_src_ff;
    nxt_copy = copy_ff;
    nxt_difn = difn_ff;
    if (wr_req && WB_ADR_I[7:2] == ADR_MODE[7:2] && wr_mode[ORG_W-1:0] <= ORG_MAX)
    begin
      nxt_origin = wr_mode[ORG_W-1:0];
    end
    if (wr_req && WB_ADR_I[7:2] == ADR_SRC[7:2])
    begin
      if (wr_src[SRC_LOC_LSB +: SRC_W] <= SRC_MAX)
      begin
        nxt_loc_src = wr_src[SRC_LOC_LSB +: SRC_W];
      end
      if (wr_src[SRC_REM_LSB +: SRC_W] <= SRC_MAX)
      begin
        nxt_rem_src = wr_src[SRC_REM_LSB +: SRC_W];
      end
      nxt_copy = wr_src[SRC_COPY_BIT];
    end
    if (wr_req && WB_ADR_I[7:2] == ADR_DIFN[7:2])
    begin
      nxt_difn = wr_difn[NUM_DI*FN_W-1:0];
    end
  end

  // local/remote mode
  always_comb
  begin
    nxt_remote = remote_ff;
    if (nxt_origin != origin_ff)
    begin
      // new origin code sets its starting mode
      if (nxt_origin == ORG_REMOTE || nxt_origin == ORG_KEY_REM)
      begin
        nxt_remote = 1'b1;
      end
      else if (nxt_origin == ORG_DIG)
      begin
        nxt_remote = lr_lvl;
      end
      else if (nxt_origin >= ORG_COMM_FIRST)
      begin
        nxt_remote = ~nxt_origin[0];
      end
      else
      begin
        nxt_remote = 1'b0;
      end
    end
    else if (origin_ff == ORG_LOCAL)
    begin
      nxt_remote = 1'b0;
    end
    else if (origin_ff == ORG_REMOTE)
    begin
      nxt_remote = 1'b1;
    end
    else if (origin_ff == ORG_KEY_LOC || origin_ff == ORG_KEY_REM)
    begin
      if (KEY_LR_TOGGLE)
      begin
        nxt_remote = ~remote_ff;
      end
    end
    else if (origin_ff == ORG_DIG)
    begin
      nxt_remote = lr_lvl;
    end
    else if (SRC_WE[comm_src])
    begin
      nxt_remote = SRC_WORD[comm_src*WORD_W + W_REM];
    end
  end

  // source command stores
  always_comb
  begin
    nxt_word = word_ff;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      if (SRC_WE[s])
      begin
        nxt_word[s*WORD_W +: WORD_W] = SRC_WORD[s*WORD_W +: WORD_W];
      end
    end
    // copy old commands into the new source
    if (copy_ff && nxt_remote != remote_ff && new_src != SRC_DIG)
    begin
      nxt_word[new_src*WORD_W +: W_REM] = act_word[W_REM-1:0];
    end
  end

  // registered outputs
  always_comb
  begin
    nxt_out = '0;
    // without an emergency input, run needs source run, source enable and general enable
    nxt_out[O_RUN] = act_word[W_RUN] & act_word[W_ENA] & ge_ok;
    nxt_out[O_QSTOP] = ~ge_ok;
    if (emg_asg)
    begin
      nxt_out[O_RUN] = |(m_emg & di_lvl);
    end
    nxt_out[O_EMERG] = emg_asg;
    nxt_out[O_REV] = act_word[W_REV];
    nxt_out[O_FWD] = ~act_word[W_REV];
    nxt_out[O_JOG] = |(m_jog & di_lvl);
    nxt_out[O_FAULT] = |(m_flt & ~di_lvl);
    nxt_out[O_ALARM] = |(m_alm & ~di_lvl);
    // any open braking input disables braking
    nxt_out[O_BRAKE] = &(~m_brk | di_lvl);
    nxt_out[O_FRST] = |(m_rst & di_rise);
    nxt_out[O_LOAD1] = load_rise & USER1_SAVED & ~MOTOR_ENABLED;
    nxt_out[O_LOAD2] = load_fall & USER2_SAVED & ~MOTOR_ENABLED;
    nxt_out[O_LREF] = (load_rise | load_fall) & MOTOR_ENABLED;
  end

  // wishbone answer, one wait state, unmapped reads zero
  always_comb
  begin
    nxt_ack = WB_CYC_I & WB_STB_I & ~ack_ff;
    nxt_rdat = '0;
    unique case (WB_ADR_I[7:2])
      ADR_MODE[7:2]: nxt_rdat = 32'(origin_ff);
      ADR_SRC[7:2]: nxt_rdat = {23'h0, copy_ff, 1'b0, rem_src_ff, 1'b0, loc_src_ff};
      ADR_DIFN[7:2]: nxt_rdat = {8'h00, difn_ff};
      ADR_STAT[7:2]: nxt_rdat = {10'h000, di_lvl, 2'b00, remote_ff, out_ff};
      default: nxt_rdat = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      origin_ff <= ORG_RST;
      loc_src_ff <= LOC_RST;
      rem_src_ff <= REM_RST;
      copy_ff <= COPY_RST;
      difn_ff <= DIFN_RST;
      remote_ff <= 1'b0;
      word_ff <= '0;
      tw_run_ff <= 1'b0;
      out_ff <= '0;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end
    else
    begin
      origin_ff <= nxt_origin;
      loc_src_ff <= nxt_loc_src;
      rem_src_ff <= nxt_rem_src;
      copy_ff <= nxt_copy;
      difn_ff <= nxt_difn;
      remote_ff <= nxt_remote;
      word_ff <= nxt_word;
      tw_run_ff <= nxt_tw_run;
      out_ff <= nxt_out;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;
  assign REMOTE_MODE = remote_ff;
  assign RUN_CMD = out_ff[O_RUN];
  assign FWD_CONTACTOR = out_ff[O_FWD];
  assign REV_CONTACTOR = out_ff[O_REV];
  assign JOG_REQ = out_ff[O_JOG];
  assign EXT_FAULT = out_ff[O_FAULT];
  assign EXT_ALARM = out_ff[O_ALARM];
  assign BRAKE_ALLOW = out_ff[O_BRAKE];
  assign QUICK_STOP = out_ff[O_QSTOP];
  assign EMERGENCY_RUN = out_ff[O_EMERG];
  assign FAULT_RESET = out_ff[O_FRST];
  assign LOAD_USER1 = out_ff[O_LOAD1];
  assign LOAD_USER2 = out_ff[O_LOAD2];
  assign LOAD_REFUSED = out_ff[O_LREF];

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  chk_fixed_local: assert property (origin_ff == ORG_LOCAL |-> !remote_ff)
    else $error("mode left local under fixed local origin");
  chk_fixed_remote: assert property (origin_ff == ORG_REMOTE |-> remote_ff)
    else $error("mode left remote under fixed remote origin");
  chk_key_toggle: assert property ((origin_ff == ORG_KEY_LOC || origin_ff == ORG_KEY_REM)
    && KEY_LR_TOGGLE && nxt_origin == origin_ff |=> remote_ff != $past(remote_ff))
    else $error("keypad key did not toggle the mode");
  chk_input_mode: assert property (origin_ff == ORG_DIG && nxt_origin == origin_ff
    |=> remote_ff == $past(lr_lvl))
    else $error("mode does not follow local/remote input");
  chk_enable_stop: assert property (!ge_ok && !emg_asg |=> !RUN_CMD && QUICK_STOP)
    else $error("run kept with general enable open");
  chk_jog_or: assert property (|(m_jog & di_lvl) |=> JOG_REQ)
    else $error("jog input closed without jog request");
  chk_brake_off: assert property (|(m_brk & ~di_lvl) |=> !BRAKE_ALLOW)
    else $error("braking allowed with an open braking input");
  chk_reset_once: assert property (FAULT_RESET |=> !FAULT_RESET)
    else $error("fault reset longer than one pulse");
  chk_load_refuse: assert property (MOTOR_ENABLED |=> !LOAD_USER1 && !LOAD_USER2)
    else $error("user memory loaded with motor enabled");
  chk_emerg_run: assert property (emg_asg |=> RUN_CMD == $past(|(m_emg & di_lvl)))
    else $error("emergency input does not drive run");
  chk_fault_open: assert property (|(m_flt & ~di_lvl) |=> EXT_FAULT)
    else $error("open no-fault input without external fault");

  cov_mode_switch: cover property (!remote_ff ##1 remote_ff);
  cov_copy: cover property (copy_ff && nxt_remote != remote_ff);
  cov_load1: cover property (LOAD_USER1);
  cov_emerg: cover property (emg_asg && RUN_CMD);
endmodule

// [tb/cmd_src_partner.sv]
// far side: operator key, digital input pins, comm source words
// assumes one bench process calls its tasks
`timescale 1ns/1ps
module cmd_src_partner
  import cmd_sel_pkg::*;
(
  input wire logic clk,
  output logic [NUM_DI-1:0] pins,
  output logic key,
  output logic [NUM_SRC-1:0] src_we,
  output logic [NUM_SRC*WORD_W-1:0] src_word
);
  initial
  begin
    pins = 6'h02;
    key = 1'b0;
    src_we = '0;
    src_word = '0;
  end
  // pins held until the levels have settled
  task automatic set_pins(input logic [NUM_DI-1:0] v);
    @(posedge clk);
    pins <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic press();
    @(posedge clk);
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic send(input int s, input logic [WORD_W-1:0] w);
    @(posedge clk);
    src_we[s] <= 1'b1;
    src_word[s*WORD_W+:WORD_W] <= w;
    @(posedge clk);
    src_we <= '0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// [tb/cmd_source_selector_test.sv]
// self-checking bench for the command source selector
// assumes the partner model drives pins, key and source words
`timescale 1ns/1ps
module cmd_source_selector_test;
  import cmd_sel_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc, stb, we, ack, mot_en, sav1, sav2;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd_o, rdat, lf;
  logic [NUM_DI-1:0] pins;
  logic key;
  logic [NUM_SRC-1:0] src_we;
  logic [NUM_SRC*WORD_W-1:0] src_word;
  logic rem_o, run_o, fwd_o, rev_o, jog_o, flt_o, alm_o;
  logic brk_o, qst_o, emg_o, frst_o, ld1_o, ld2_o, ldr_o;
  int miscompares = 0;
  int comparisons = 0;
  int n_frst = 0;
  int n_ld1 = 0;
  int n_ld2 = 0;
  int n_ldr = 0;
  int rem_m;
  always #2.5 core_clk = ~core_clk;
  cmd_src_partner pt (.clk(core_clk), .pins(pins), .key(key), .src_we(src_we),
    .src_word(src_word));
  cmd_source_selector uut (.CORE_CLK(core_clk), .RESET(reset), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(rd_o), .WB_ACK_O(ack), .DIG_INPUT(pins), .KEY_LR_TOGGLE(key),
    .SRC_WE(src_we), .SRC_WORD(src_word), .MOTOR_ENABLED(mot_en),
    .USER1_SAVED(sav1), .USER2_SAVED(sav2), .REMOTE_MODE(rem_o), .RUN_CMD(run_o),
    .FWD_CONTACTOR(fwd_o), .REV_CONTACTOR(rev_o), .JOG_REQ(jog_o),
    .EXT_FAULT(flt_o), .EXT_ALARM(alm_o), .BRAKE_ALLOW(brk_o), .QUICK_STOP(qst_o),
    .EMERGENCY_RUN(emg_o), .FAULT_RESET(frst_o), .LOAD_USER1(ld1_o),
    .LOAD_USER2(ld2_o), .LOAD_REFUSED(ldr_o));
  // pulse counters
  always @(posedge core_clk)
  begin
    if (frst_o === 1'b1)
      n_frst++;
    if (ld1_o === 1'b1)
      n_ld1++;
    if (ld2_o === 1'b1)
      n_ld2++;
    if (ldr_o === 1'b1)
      n_ldr++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1)
    begin
      miscompares++;
      close_out();
    end
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, '0, 4'hf);
    chk(rdat, e);
  endtask
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    dat = '0;
    mot_en = 1'b0;
    sav1 = 1'b1;
    sav2 = 1'b1;
    lf = 32'hec90280e;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADR_MODE, 32'h2);
    rd(ADR_SRC, 32'h10);
    rd(ADR_DIFN, 32'h32);
    rd(8'h10, 32'h0);
    rd(ADR_STAT, 32'h00020042);
    lf = lfsr(lf);
    wb(1'b1, ADR_DIFN, {lf[31:8], 8'h45}, 4'h1);
    rd(ADR_DIFN, 32'h45);
    chk(rem_o, 32'h0);
    $display("reset values done");
    rem_m = 0;
    for (int c = 0; c < 14; c++)
    begin
      if (c == 4)
        continue;
      wr(ADR_MODE, 32'(c));
      if (c < 13)
        rem_m = int'(c == 1 || c == 3 || (c > 4 && c % 2 == 0));
      chk(rem_o, 32'(rem_m));
      pt.press();
      if (c == 2 || c == 3)
        rem_m = 1 - rem_m;
      chk(rem_o, 32'(rem_m));
      if (c > 4 && c < 13)
      begin
        pt.send((c - 5) / 2 + 2, (rem_m == 1) ? 4'h0 : 4'h8);
        rem_m = 1 - rem_m;
      end
      chk(rem_o, 32'(rem_m));
    end
    wr(ADR_DIFN, 32'h500);
    wr(ADR_MODE, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr(lf);
      pt.set_pins({3'h0, lf[0], 2'h0});
      pt.press();
      chk(rem_o, {31'h0, lf[0]});
    end
    $display("mode origin done");
    wr(ADR_MODE, 32'h2);
    wr(ADR_DIFN, 32'h041);
    pt.set_pins(6'h02);
    pt.send(0, 4'h3);
    chk(run_o, 32'h1);
    pt.press();
    chk(run_o, 32'h0);
    pt.set_pins(6'h03);
    chk(run_o, 32'h1);
    pt.set_pins(6'h01);
    chk({run_o, qst_o}, 32'h1);
    wr(ADR_DIFN, 32'he41);
    pt.set_pins(6'h05);
    chk({run_o, emg_o}, 32'h3);
    wr(ADR_DIFN, 32'h041);
    pt.set_pins(6'h02);
    pt.press();
    wr(ADR_SRC, 32'h020);
    pt.send(2, 4'h0);
    pt.press();
    chk(run_o, 32'h0);
    pt.press();
    chk(run_o, 32'h1);
    wr(ADR_SRC, 32'h120);
    pt.press();
    chk(run_o, 32'h1);
    for (int s = 3; s < 6; s++)
    begin
      wr(ADR_SRC, 32'(s) << 4);
      chk(run_o, 32'h0);
      pt.send(s, 4'h3);
      chk(run_o, 32'h1);
    end
    $display("command source done");
    wr(ADR_SRC, 32'h011);
    wr(ADR_DIFN, 32'ha98766);
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      pt.set_pins(lf[5:0]);
      chk(jog_o, {31'h0, lf[0] | lf[1]});
      chk({fwd_o, rev_o}, {30'h0, ~lf[2], lf[2]});
      chk({flt_o, alm_o}, {30'h0, ~lf[3], ~lf[4]});
      chk(brk_o, {31'h0, lf[5]});
    end
    $display("level inputs done");
    pt.set_pins(6'h00);
    wr(ADR_DIFN, 32'hcb);
    n_frst = 0;
    n_ld1 = 0;
    n_ld2 = 0;
    n_ldr = 0;
    pt.set_pins(6'h01);
    pt.set_pins(6'h01);
    chk(n_frst, 32'h1);
    pt.set_pins(6'h00);
    pt.set_pins(6'h01);
    chk(n_frst, 32'h2);
    pt.set_pins(6'h02);
    chk(n_ld1, 32'h1);
    pt.set_pins(6'h00);
    chk(n_ld2, 32'h1);
    @(posedge core_clk);
    mot_en <= 1'b1;
    pt.set_pins(6'h02);
    chk({n_ld1[15:0], n_ldr[15:0]}, 32'h10001);
    @(posedge core_clk);
    mot_en <= 1'b0;
    sav1 <= 1'b0;
    pt.set_pins(6'h00);
    pt.set_pins(6'h02);
    chk({n_ld1[15:0], n_ld2[15:0]}, 32'h10002);
    $display("edge inputs done");
    wr(ADR_DIFN, 32'h32);
    pt.set_pins(6'h03);
    chk(run_o, 32'h1);
    pt.set_pins(6'h02);
    chk(run_o, 32'h1);
    pt.set_pins(6'h00);
    pt.set_pins(6'h02);
    chk(run_o, 32'h0);
    $display("three-wire done");
    close_out();
  end
endmodule
